// file: design/bpac_addr_cmp.sv
// Address comparator with byte masking and page extension
`timescale 1ns/1ps
module bpac_addr_cmp (
    bpac_cmp_if.cmp    c,
    input  wire logic [15:0] cpu_addr,
    input  wire logic [5:0]  page,
    input  wire logic        page_sel
);
    import bpac_pkg::*;
    logic hi_on;
    logic lo_on;
    logic pg_eq;
    logic hi_eq;
    logic lo_eq;
    always_comb begin
        // Masks only honoured in dual/full; 1:0 forced to full compare
        hi_on = !(c.masks_on && c.mask_hi && c.mask_lo);
        lo_on = !(c.masks_on && c.mask_lo);
        pg_eq = c.ref_word[PAGE_LSB +: PAGE_W] == page;
        lo_eq = c.ref_word[7:0] == cpu_addr[7:0];
        if (page_sel)
            hi_eq = c.ref_word[13:8] == cpu_addr[13:8];
        else
            hi_eq = c.ref_word[15:8] == cpu_addr[15:8];
        if (c.masks_on && c.mask_hi && c.mask_lo)
            c.hit = page_sel && pg_eq;
        else
            c.hit = (!page_sel || pg_eq) && (!hi_on || hi_eq) && (!lo_on || lo_eq);
    end
endmodule : bpac_addr_cmp

// file: design/bpac_cmp_if.sv
// Interface: settings and match result of one address comparator
`timescale 1ns/1ps
interface bpac_cmp_if;
    logic [21:0] ref_word;
    logic        mask_hi;
    logic        mask_lo;
    logic        masks_on;
    logic        hit;
    modport ctrl (output ref_word, output mask_hi, output mask_lo, output masks_on, input hit);
    modport cmp  (input ref_word, input mask_hi, input mask_lo, input masks_on, output hit);
endinterface : bpac_cmp_if

// file: design/bpac_pkg.sv
// Package: constants and types for the breakpoint address compare block
package bpac_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_MODE   = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_COMPA  = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_COMPB  = 12'h00C;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_CLEAR  = 12'h014;
    localparam logic [ADDR_W-1:0] OFF_ENABLE = 12'h018;
    localparam logic [ADDR_W-1:0] OFF_DATA   = 12'h01C;
    // Control register fields
    localparam int CTRL_A_MASK_HI = 7;
    localparam int CTRL_A_MASK_LO = 6;
    localparam int CTRL_B_MASK_HI = 5;
    localparam int CTRL_B_MASK_LO = 4;
    localparam int CTRL_DIR_EN    = 3;
    localparam int CTRL_DIR_VAL   = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Comparator word: page[21:16], high[15:8], low[7:0]
    localparam int PAGE_LSB = 16;
    localparam int PAGE_W   = 6;
    localparam int PAGE_ADDR_LSB = 14;
    // Status bits
    localparam int ST_A = 0;
    localparam int ST_B = 1;
    localparam int ST_W = 2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {BPAC_MODE_OFF, BPAC_MODE_DUAL, BPAC_MODE_FULL} bpac_mode_t;
endpackage : bpac_pkg

// file: design/bpac_top.sv
// Top: breakpoint address compare with AXI4-Lite register access
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
// Contract
// - In dual or full mode bits 7:6 mask the high and/or low byte of comparator A.
// - A with mask x:0 and a page selected compares page bits plus address 13:0.
// - A with mask x:0 and no page compares address 15:0.
// - A mask 1:0 compares all lines, ignoring the high mask bit.
// - A mask 1:1 matches any access to the page, only during page accesses.
// - In dual mode bits 5:4 mask the high and/or low byte of comparator B.
// - B with mask x:0 and a page selected compares page bits plus address 13:0.
// - B with mask x:0 and no page compares address 15:0.
// - B mask 1:0 compares all lines, ignoring its high mask bit.
// - B mask 1:1 matches any access to the page, only during page accesses.
// - In full mode bits 5:4 mask the high and/or low byte of the data value.
// - Bit 3 includes the bus direction in comparator A matching.
// - Bit 2 picks write (0) or read (1) for A, unused when bit 3 is clear.
module bpac_top (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [15:0]            cpu_addr,
    input  wire logic [5:0]             cpu_page,
    input  wire logic                   cpu_page_sel,
    input  wire logic                   cpu_read,
    input  wire logic [15:0]            cpu_data,
    input  wire logic                   cpu_valid,
    output logic                        irq,
    output logic                        hit_a,
    output logic                        hit_b,
    input  wire logic [bpac_pkg::ADDR_W-1:0] s_awaddr,
    input  wire logic                   s_awvalid,
    output logic                        s_awready,
    input  wire logic [bpac_pkg::DATA_W-1:0] s_wdata,
    input  wire logic [3:0]             s_wstrb,
    input  wire logic                   s_wvalid,
    output logic                        s_wready,
    output logic [1:0]                  s_bresp,
    output logic                        s_bvalid,
    input  wire logic                   s_bready,
    input  wire logic [bpac_pkg::ADDR_W-1:0] s_araddr,
    input  wire logic                   s_arvalid,
    output logic                        s_arready,
    output logic [bpac_pkg::DATA_W-1:0] s_rdata,
    output logic [1:0]                  s_rresp,
    output logic                        s_rvalid,
    input  wire logic                   s_rready
);
    import bpac_pkg::*;

    logic [7:0]        ctrl_q;
    bpac_mode_t        mode_q;
    logic [21:0]       comp_a_q;
    logic [21:0]       comp_b_q;
    logic [15:0]       data_q;
    logic [ST_W-1:0]   status_q;
    logic [ST_W-1:0]   enable_q;
    logic [ADDR_W-1:0] aw_q;
    logic [DATA_W-1:0] w_q;
    logic [3:0]        ws_q;
    logic              aw_have_q;
    logic              w_have_q;
    logic              wr_go;
    logic              wr_ok;
    logic [ST_W-1:0]   clr_d;
    logic              dir_ok;
    logic              data_ok;
    logic              ev_a;
    logic              ev_b;
    logic [DATA_W-1:0] rd_d;
    logic              rd_ok;

    bpac_cmp_if ca ();
    bpac_cmp_if cb ();

    assign ca.ref_word = comp_a_q;
    assign ca.mask_hi  = ctrl_q[CTRL_A_MASK_HI];
    assign ca.mask_lo  = ctrl_q[CTRL_A_MASK_LO];
    assign ca.masks_on = mode_q != BPAC_MODE_OFF;
    assign cb.ref_word = comp_b_q;
    assign cb.mask_hi  = ctrl_q[CTRL_B_MASK_HI];
    assign cb.mask_lo  = ctrl_q[CTRL_B_MASK_LO];
    assign cb.masks_on = mode_q == BPAC_MODE_DUAL;

    bpac_addr_cmp u_cmp_a (
        .c        (ca.cmp),
        .cpu_addr (cpu_addr),
        .page     (cpu_page),
        .page_sel (cpu_page_sel)
    );
    bpac_addr_cmp u_cmp_b (
        .c        (cb.cmp),
        .cpu_addr (cpu_addr),
        .page     (cpu_page),
        .page_sel (cpu_page_sel)
    );

    // Direction qualifier for comparator A
    assign dir_ok = !ctrl_q[CTRL_DIR_EN] || (ctrl_q[CTRL_DIR_VAL] == cpu_read);

    // Full mode: bits 5:4 mask data bytes instead of address B
    always_comb begin
        data_ok = 1'b1;
        if (mode_q == BPAC_MODE_FULL) begin
            if (!ctrl_q[CTRL_B_MASK_HI] && data_q[15:8] != cpu_data[15:8])
                data_ok = 1'b0;
            if (!ctrl_q[CTRL_B_MASK_LO] && data_q[7:0] != cpu_data[7:0])
                data_ok = 1'b0;
        end
    end

    assign ev_a = cpu_valid && mode_q != BPAC_MODE_OFF && ca.hit && dir_ok
                  && (mode_q != BPAC_MODE_FULL || data_ok);
    assign ev_b = cpu_valid && mode_q == BPAC_MODE_DUAL && cb.hit;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hit_a <= 1'b0;
            hit_b <= 1'b0;
        end else begin
            hit_a <= ev_a;
            hit_b <= ev_b;
        end
    end

    // Write channel capture, either order
    assign wr_go = aw_have_q && w_have_q && !s_bvalid;
    assign wr_ok = aw_q == OFF_CTRL || aw_q == OFF_MODE || aw_q == OFF_COMPA
                   || aw_q == OFF_COMPB || aw_q == OFF_CLEAR || aw_q == OFF_ENABLE
                   || aw_q == OFF_DATA || aw_q == OFF_STATUS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_q      <= '0;
            w_q       <= '0;
            ws_q      <= 4'h0;
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            s_bvalid  <= 1'b0;
            s_bresp   <= RESP_OKAY;
        end else begin
            s_awready <= !aw_have_q && !(s_awvalid && s_awready);
            s_wready  <= !w_have_q && !(s_wvalid && s_wready);
            if (s_awvalid && s_awready) begin
                aw_have_q <= 1'b1;
                aw_q      <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_have_q <= 1'b1;
                w_q      <= s_wdata;
                ws_q     <= s_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                s_bvalid  <= 1'b1;
                s_bresp   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // Register writes; lane 0 covers control fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q   <= CTRL_RESET;
            mode_q   <= BPAC_MODE_OFF;
            comp_a_q <= '0;
            comp_b_q <= '0;
            data_q   <= 16'h0000;
            enable_q <= '0;
        end else if (wr_go) begin
            if (aw_q == OFF_CTRL && ws_q[0])
                ctrl_q <= w_q[7:0];
            else if (aw_q == OFF_MODE && ws_q[0])
                mode_q <= (w_q[1:0] == 2'h3) ? BPAC_MODE_OFF : bpac_mode_t'(w_q[1:0]);
            else if (aw_q == OFF_COMPA) begin
                // Lane 2 carries only the six page bits
                if (ws_q[0])
                    comp_a_q[7:0] <= w_q[7:0];
                if (ws_q[1])
                    comp_a_q[15:8] <= w_q[15:8];
                if (ws_q[2])
                    comp_a_q[21:16] <= w_q[21:16];
            end else if (aw_q == OFF_COMPB) begin
                if (ws_q[0])
                    comp_b_q[7:0] <= w_q[7:0];
                if (ws_q[1])
                    comp_b_q[15:8] <= w_q[15:8];
                if (ws_q[2])
                    comp_b_q[21:16] <= w_q[21:16];
            end
            else if (aw_q == OFF_DATA && ws_q[1:0] == 2'h3)
                data_q <= w_q[15:0];
            else if (aw_q == OFF_ENABLE && ws_q[0])
                enable_q <= w_q[ST_W-1:0];
        end
    end

    // Sticky status; a new hit wins over a clear in the same cycle
    assign clr_d = (wr_go && aw_q == OFF_CLEAR && ws_q[0]) ? w_q[ST_W-1:0] : '0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= '0;
            irq      <= 1'b0;
        end else begin
            status_q <= (status_q & ~clr_d) | {ev_b, ev_a};
            irq      <= |(((status_q & ~clr_d) | {ev_b, ev_a}) & enable_q);
        end
    end

    // Read channel
    always_comb begin
        rd_d  = '0;
        rd_ok = 1'b1;
        if (s_araddr == OFF_CTRL)
            rd_d[7:0] = ctrl_q;
        else if (s_araddr == OFF_MODE)
            rd_d[1:0] = mode_q;
        else if (s_araddr == OFF_COMPA)
            rd_d[21:0] = comp_a_q;
        else if (s_araddr == OFF_COMPB)
            rd_d[21:0] = comp_b_q;
        else if (s_araddr == OFF_STATUS)
            rd_d[ST_W-1:0] = status_q;
        else if (s_araddr == OFF_ENABLE)
            rd_d[ST_W-1:0] = enable_q;
        else if (s_araddr == OFF_DATA)
            rd_d[15:0] = data_q;
        else if (s_araddr != OFF_CLEAR)
            rd_ok = 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= '0;
            s_rresp   <= RESP_OKAY;
        end else begin
            s_arready <= !s_rvalid && !(s_arvalid && s_arready);
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rdata  <= rd_d;
                s_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // Checks
    page_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_q == BPAC_MODE_DUAL && ctrl_q[7:6] == 2'h3 && cpu_valid && !cpu_page_sel
        |=> !hit_a) else $error("page-only match without page access");
    dir_qual_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_q[CTRL_DIR_EN] && ctrl_q[CTRL_DIR_VAL] != cpu_read |=> !hit_a)
        else $error("direction qualifier ignored");
    full_cmp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_q == BPAC_MODE_DUAL && !ctrl_q[6] && cpu_valid && !cpu_page_sel
        && !ctrl_q[CTRL_DIR_EN] && cpu_addr == comp_a_q[15:0] |=> hit_a)
        else $error("16-bit match missed");
    low_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_q == BPAC_MODE_DUAL && ctrl_q[7:6] == 2'h1 && cpu_valid && !cpu_page_sel
        && cpu_addr[15:8] != comp_a_q[15:8] |=> !hit_a)
        else $error("low mask dropped high byte");
    comp_b_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_q != BPAC_MODE_DUAL |=> !hit_b) else $error("comparator B outside dual");
    page_cmp_b_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cpu_page_sel && cpu_page != comp_b_q[21:16] |=> !hit_b)
        else $error("page bits ignored on B");
    status_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
        hit_a |-> status_q[ST_A]) else $error("status lost a hit");
    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(status_q[ST_A]) && enable_q[ST_A] && $stable(enable_q) |-> ##[0:1] irq)
        else $error("interrupt not raised");

    // Off mode silences both comparators whatever the masks say
    mode_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_q == BPAC_MODE_OFF |=> !hit_a && !hit_b)
        else $error("hit while compare is off");
    idle_bus_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !cpu_valid |=> !hit_a && !hit_b)
        else $error("hit without a bus cycle");
    page_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_q == BPAC_MODE_DUAL && ctrl_q[7:6] == 2'h3 && cpu_valid && cpu_page_sel
        && cpu_page == comp_a_q[21:16] && !ctrl_q[CTRL_DIR_EN] |=> hit_a)
        else $error("page match missed on A");
    page_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_q == BPAC_MODE_DUAL && !ctrl_q[6] && cpu_valid && cpu_page_sel
        && cpu_page == comp_a_q[21:16] && cpu_addr[13:0] == comp_a_q[13:0]
        && !ctrl_q[CTRL_DIR_EN] |=> hit_a)
        else $error("20-bit match missed on A");
    high_kept_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_q == BPAC_MODE_DUAL && ctrl_q[7:6] == 2'h2 && cpu_valid && !cpu_page_sel
        && cpu_addr[15:8] != comp_a_q[15:8] |=> !hit_a)
        else $error("high mask honoured on A");
    full_cmp_b_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_q == BPAC_MODE_DUAL && !ctrl_q[4] && cpu_valid && !cpu_page_sel
        && cpu_addr == comp_b_q[15:0] |=> hit_b)
        else $error("16-bit match missed on B");
    high_kept_b_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_q == BPAC_MODE_DUAL && ctrl_q[5:4] == 2'h2 && cpu_valid && !cpu_page_sel
        && cpu_addr[15:8] != comp_b_q[15:8] |=> !hit_b)
        else $error("high mask honoured on B");
    page_only_b_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_q == BPAC_MODE_DUAL && ctrl_q[5:4] == 2'h3 && cpu_valid && cpu_page_sel
        && cpu_page == comp_b_q[21:16] |=> hit_b)
        else $error("page match missed on B");
    // Data low byte compared unless bit 4 masks it
    data_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_q == BPAC_MODE_FULL && !ctrl_q[CTRL_B_MASK_LO]
        && cpu_data[7:0] != data_q[7:0] |=> !hit_a)
        else $error("data mismatch ignored");
    dir_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_q == BPAC_MODE_DUAL && ctrl_q[7:2] == 6'h03 && cpu_valid && !cpu_page_sel
        && cpu_read && cpu_addr == comp_a_q[15:0] |=> hit_a)
        else $error("read match missed");

    // Bus answers stand until taken
    bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write response dropped");
    rvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read data dropped");
    aw_take_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_awvalid && s_awready |=> !s_awready)
        else $error("second address taken");
    w_take_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_wvalid && s_wready |=> !s_wready)
        else $error("second data taken");
    ar_take_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_arvalid && s_arready |=> !s_arready)
        else $error("second read taken");
    // No disable here: reset itself is what is checked
    reset_quiet_a: assert property (@(posedge aclk)
        !aresetn |=> !s_awready && !s_arready && !irq && !hit_a && !hit_b)
        else $error("outputs active after reset");
endmodule : bpac_top

// file: verification/bpac_cpu_model.sv
// CPU core bus model: one access per call, released lines inverted when idle
`timescale 1ns/1ps
module bpac_cpu_model (
    input  wire logic  aclk,
    output logic [15:0] cpu_addr,
    output logic [5:0]  cpu_page,
    output logic        cpu_page_sel,
    output logic        cpu_read,
    output logic [15:0] cpu_data,
    output logic        cpu_valid
);
    // Page aliasing is left to software; the model never relies on it
    initial begin
        cpu_addr     = 16'h0000;
        cpu_page     = 6'h00;
        cpu_page_sel = 1'b0;
        cpu_read     = 1'b0;
        cpu_data     = 16'h0000;
        cpu_valid    = 1'b0;
    end

    task automatic access(input logic [15:0] a, input logic [5:0] p, input logic ps,
                          input logic rd, input logic [15:0] d);
        @(posedge aclk);
        cpu_addr     <= a;
        cpu_page     <= p;
        cpu_page_sel <= ps;
        cpu_read     <= rd;
        cpu_data     <= d;
        cpu_valid    <= 1'b1;
    endtask : access

    // Stale values would hide a missing valid qualifier, so flip them
    task automatic idle();
        @(posedge aclk);
        cpu_addr     <= ~cpu_addr;
        cpu_page     <= ~cpu_page;
        cpu_page_sel <= ~cpu_page_sel;
        cpu_read     <= ~cpu_read;
        cpu_data     <= ~cpu_data;
        cpu_valid    <= 1'b0;
    endtask : idle
endmodule : bpac_cpu_model

// file: verification/bpac_tb_top.sv
// Testbench: table of compare cases, interrupts, bus errors and reset
`timescale 1ns/1ps
module bpac_tb_top;
    import bpac_pkg::*;
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [1:0]  mode;
        logic [15:0] addr;
        logic [5:0]  page;
        logic        psel;
        logic        rd;
        logic [15:0] data;
        logic        ea;
        logic        eb;
    } bpac_row_t;
    localparam int NROW = 26;
    localparam bpac_row_t ROWS [NROW] = '{
        '{8'h00,2'h1,16'h1234,6'h00,1'h0,1'h0,16'hBEEF,1'h1,1'h0},
        '{8'h00,2'h1,16'h1235,6'h00,1'h0,1'h0,16'hBEEF,1'h0,1'h0},
        '{8'h00,2'h1,16'h5678,6'h00,1'h0,1'h0,16'hBEEF,1'h0,1'h1},
        '{8'h00,2'h1,16'hD234,6'h05,1'h1,1'h0,16'hBEEF,1'h1,1'h0},
        '{8'h00,2'h1,16'h1234,6'h06,1'h1,1'h0,16'hBEEF,1'h0,1'h0},
        '{8'h00,2'h1,16'h9678,6'h0A,1'h1,1'h0,16'hBEEF,1'h0,1'h1},
        '{8'h80,2'h1,16'h1234,6'h00,1'h0,1'h0,16'hBEEF,1'h1,1'h0},
        '{8'h80,2'h1,16'h0034,6'h00,1'h0,1'h0,16'hBEEF,1'h0,1'h0},
        '{8'h40,2'h1,16'h12FF,6'h00,1'h0,1'h0,16'hBEEF,1'h1,1'h0},
        '{8'h40,2'h1,16'h1334,6'h00,1'h0,1'h0,16'hBEEF,1'h0,1'h0},
        '{8'hC0,2'h1,16'h0000,6'h05,1'h1,1'h0,16'hBEEF,1'h1,1'h0},
        '{8'hC0,2'h1,16'h1234,6'h00,1'h0,1'h0,16'hBEEF,1'h0,1'h0},
        '{8'h20,2'h1,16'h5678,6'h00,1'h0,1'h0,16'hBEEF,1'h0,1'h1},
        '{8'h20,2'h1,16'h0078,6'h00,1'h0,1'h0,16'hBEEF,1'h0,1'h0},
        '{8'h10,2'h1,16'h56AA,6'h00,1'h0,1'h0,16'hBEEF,1'h0,1'h1},
        '{8'h30,2'h1,16'h0000,6'h0A,1'h1,1'h0,16'hBEEF,1'h0,1'h1},
        '{8'h30,2'h1,16'h5678,6'h00,1'h0,1'h0,16'hBEEF,1'h0,1'h0},
        '{8'h08,2'h1,16'h1234,6'h00,1'h0,1'h1,16'hBEEF,1'h0,1'h0},
        '{8'h08,2'h1,16'h1234,6'h00,1'h0,1'h0,16'hBEEF,1'h1,1'h0},
        '{8'h0C,2'h1,16'h1234,6'h00,1'h0,1'h1,16'hBEEF,1'h1,1'h0},
        '{8'h04,2'h1,16'h1234,6'h00,1'h0,1'h0,16'hBEEF,1'h1,1'h0},
        '{8'h00,2'h0,16'h1234,6'h00,1'h0,1'h0,16'hBEEF,1'h0,1'h0},
        '{8'h00,2'h2,16'h1234,6'h00,1'h0,1'h0,16'hBEEF,1'h1,1'h0},
        '{8'h00,2'h2,16'h1234,6'h00,1'h0,1'h0,16'hBEEE,1'h0,1'h0},
        '{8'h10,2'h2,16'h1234,6'h00,1'h0,1'h0,16'hBEEE,1'h1,1'h0},
        '{8'h00,2'h2,16'h5678,6'h00,1'h0,1'h0,16'hBEEF,1'h0,1'h0}
    };
    logic              aclk = 1'b0;
    logic              aresetn, irq, hit_a, hit_b;
    logic [15:0]       cpu_addr, cpu_data;
    logic [5:0]        cpu_page;
    logic              cpu_page_sel, cpu_read, cpu_valid;
    logic [ADDR_W-1:0] s_awaddr, s_araddr;
    logic [DATA_W-1:0] s_wdata, s_rdata, rd_d;
    logic [3:0]        s_wstrb;
    logic [1:0]        s_bresp, s_rresp, rsp;
    logic              s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic              s_arvalid, s_arready, s_rvalid, s_rready;
    int                error_cnt = 0;
    int                compares = 0;

    always #5 aclk = ~aclk;

    bpac_top i_bpac_top (.aclk, .aresetn, .cpu_addr, .cpu_page, .cpu_page_sel, .cpu_read,
        .cpu_data, .cpu_valid, .irq, .hit_a, .hit_b, .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
        .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
    bpac_cpu_model i_bpac_cpu_model (.aclk, .cpu_addr, .cpu_page, .cpu_page_sel, .cpu_read,
        .cpu_data, .cpu_valid);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_awaddr  <= a;
        s_wdata   <= d;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        rsp = s_bresp;
        s_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [ADDR_W-1:0] a);
        @(posedge aclk);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        rd_d = s_rdata;
        rsp = s_rresp;
        s_rready <= 1'b0;
    endtask : axi_rd

    task automatic end_of_test();
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    // Whole run is a few hundred cycles; this span only catches a hang
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end

    initial begin
        aresetn = 1'b0;
        {s_awaddr, s_araddr, s_wdata} = '0;
        s_wstrb = 4'hF;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_wr(OFF_COMPA, 32'h0005_1234);
        axi_wr(OFF_COMPB, 32'h000A_5678);
        axi_wr(OFF_DATA, 32'h0000_BEEF);
        for (int i = 0; i < NROW; i++) begin
            axi_wr(OFF_CTRL, {24'h000000, ROWS[i].ctrl});
            axi_wr(OFF_MODE, {30'h00000000, ROWS[i].mode});
            i_bpac_cpu_model.access(ROWS[i].addr, ROWS[i].page, ROWS[i].psel, ROWS[i].rd,
                                    ROWS[i].data);
            i_bpac_cpu_model.idle();
            #1;
            chk({30'h0, hit_a, hit_b}, {30'h0, ROWS[i].ea, ROWS[i].eb}, "row hits");
        end
        // Back-to-back accesses: each hit is its own one-cycle pulse
        axi_wr(OFF_CTRL, 32'h0000_0000);
        axi_wr(OFF_MODE, 32'h0000_0001);
        i_bpac_cpu_model.access(16'h1234, 6'h00, 1'b0, 1'b0, 16'h0000);
        i_bpac_cpu_model.access(16'h5678, 6'h00, 1'b0, 1'b0, 16'h0000);
        #1;
        chk({30'h0, hit_a, hit_b}, 32'h0000_0002, "first of pair");
        i_bpac_cpu_model.idle();
        #1;
        chk({30'h0, hit_a, hit_b}, 32'h0000_0001, "second of pair");
        // Sticky status, enable mask and clear
        axi_rd(OFF_STATUS);
        chk(rd_d, 32'h0000_0003, "status sticky");
        chk({31'h0, irq}, 32'h0000_0000, "irq masked");
        axi_wr(OFF_ENABLE, 32'h0000_0001);
        @(posedge aclk);
        #1;
        chk({31'h0, irq}, 32'h0000_0001, "irq enabled");
        axi_wr(OFF_CLEAR, 32'h0000_0001);
        axi_rd(OFF_STATUS);
        chk(rd_d, 32'h0000_0002, "status after clear");
        chk({31'h0, irq}, 32'h0000_0000, "irq after clear");
        axi_rd(OFF_CLEAR);
        chk({rd_d[29:0], rsp}, {30'h0, RESP_OKAY}, "clear reads zero");
        axi_wr(OFF_CLEAR, 32'h0000_0002);
        i_bpac_cpu_model.access(16'h1234, 6'h00, 1'b0, 1'b0, 16'h0000);
        i_bpac_cpu_model.idle();
        #1;
        chk({30'h0, hit_a, irq}, 32'h0000_0003, "irq with hit");
        // Unmapped place and control width
        axi_wr(12'h020, 32'hFFFF_FFFF);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped write");
        axi_rd(12'h020);
        chk({rd_d[29:0], rsp}, {30'h0, RESP_SLVERR}, "unmapped read");
        axi_wr(OFF_CTRL, 32'hFFFF_FFFF);
        axi_rd(OFF_CTRL);
        chk(rd_d, 32'h0000_00FF, "ctrl width");
        // Reset in mid-run clears every register
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk({31'h0, irq}, 32'h0000_0000, "irq in reset");
        axi_rd(OFF_CTRL);
        chk(rd_d, 32'h0000_0000, "ctrl reset");
        axi_rd(OFF_COMPA);
        chk(rd_d, 32'h0000_0000, "comparator reset");
        axi_rd(OFF_ENABLE);
        chk(rd_d, 32'h0000_0000, "enable reset");
        axi_rd(OFF_STATUS);
        chk(rd_d, 32'h0000_0000, "status reset");
        end_of_test();
    end
endmodule : bpac_tb_top
